// ===== core/pco_pkg.sv
// pco_pkg: constants for the port c alternate-function override block
// assumes a 32-bit classic wishbone slave with word-aligned registers
package pco_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned PCO_PINS  = 8;   // pins on the port
  localparam int unsigned PCO_AW    = 8;   // byte address width
  localparam int unsigned PCO_DW    = 32;  // bus data width

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] PCO_OFS_OUT   = 8'h00; // output value / pull-up
  localparam logic [7:0] PCO_OFS_DIR   = 8'h04; // direction, 1 = output
  localparam logic [7:0] PCO_OFS_PIN   = 8'h08; // sampled pin levels, ro
  localparam logic [7:0] PCO_OFS_CTRL  = 8'h0c; // digital disables, pull-up

  ////////////////////////////////////////////////////////////////////////////
  // control register field positions
  localparam int unsigned PCO_CTRL_PUD   = 0;  // global pull-up disable
  localparam int unsigned PCO_CTRL_AD8D  = 4;  // pin 4 digital disable
  localparam int unsigned PCO_CTRL_AD9D  = 5;  // pin 5 digital disable
  localparam int unsigned PCO_CTRL_AD10D = 6;  // pin 6 digital disable

  ////////////////////////////////////////////////////////////////////////////
  // pin positions of the alternate functions
  localparam int unsigned PCO_PIN_CONV  = 7;  // converter output pin
  localparam int unsigned PCO_PIN_S2O3  = 3;  // stage 2 out 3 / timer1 clk
  localparam int unsigned PCO_PIN_S2O2  = 2;  // stage 2 out 2 / timer0 clk
  localparam int unsigned PCO_PIN_CMPB  = 1;  // compare b / stage1 input
  localparam int unsigned PCO_PIN_S1O0  = 0;  // stage 1 out 0 / irq 3

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] PCO_RST_OUT  = 8'h00;
  localparam logic [7:0] PCO_RST_DIR  = 8'h00;
  localparam logic [7:0] PCO_RST_CTRL = 8'h00;
  localparam logic [7:0] PCO_RST_PIN  = 8'h00;

endpackage : pco_pkg

// ===== core/pco_port_c_override.sv
// pco_port_c_override: port c registers and pad override logic
// assumes synchronous pad inputs, one clock, classic wishbone master
//
// Operation
// - converter enable forces pin 7 input
// - input enable override on pins 7..4, zero
// - stage enables force pins 3,2,0 output
// - stage/compare values drive pins 3,2,1,0
// - compare b enable gates pin 1 value
// - no pull-up override on pins 3..0
// - pin 0 input stays on for irq 3
// - pin 0 carries stage 1 output 0
`timescale 1ns/100ps
`default_nettype none

module pco_port_c_override
  import pco_pkg::*;
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [PCO_AW-1:0]   wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [PCO_DW-1:0]   wb_dat_i,
  output logic      [PCO_DW-1:0]   wb_dat_o,
  output logic                     wb_ack_o,
  // peripheral override requests
  input  wire logic                converter_output_enable_i,
  input  wire logic                stage2_out3_enable_i,
  input  wire logic                stage2_out2_enable_i,
  input  wire logic                stage1_out0_enable_i,
  input  wire logic                stage2_out3_value_i,
  input  wire logic                stage2_out2_value_i,
  input  wire logic                stage1_out0_value_i,
  input  wire logic                timer1_compare_b_out_i,
  input  wire logic                timer1_compare_b_enable_i,
  input  wire logic                ext_irq3_enable_i,
  // inputs delivered to peripherals
  output logic                     ext_irq3_input_o,
  output logic                     stage1_digital_input_o,
  output logic                     timer0_clock_input_o,
  output logic                     timer1_clock_input_o,
  // pads
  input  wire logic [PCO_PINS-1:0] pad_in_i,
  output logic      [PCO_PINS-1:0] pad_out_o,
  output logic      [PCO_PINS-1:0] pad_oe_o,
  output logic      [PCO_PINS-1:0] pad_pullup_o,
  output logic      [PCO_PINS-1:0] pad_input_en_o
);

  ////////////////////////////////////////////////////////////////////////////
  // override mux: enable picks the override, else the port setting
  function automatic logic ovr(input logic en, input logic val,
                               input logic base);
    ovr = en ? val : base;
  endfunction : ovr

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]        out_q,  out_d;   // port output value / pull-up bits
  logic [7:0]        dir_q,  dir_d;   // port direction bits
  logic [7:0]        ctrl_q, ctrl_d;  // digital disables and pull-up off
  logic [7:0]        pin_q,  pin_d;   // sampled, gated pad levels
  logic              ack_q,  ack_d;   // bus answer
  logic [PCO_DW-1:0] rdat_q, rdat_d;  // registered read data
  logic              req;             // live bus request
  logic              wr_now;          // write commits this edge
  logic [7:0]        direction_override_enable, direction_override_value;      // direction override pair
  logic [7:0]        port_value_override_enable, port_value_override_value;      // value override pair
  logic [7:0]        input_enable_override_enable, input_enable_override_value;    // input enable override pair

  assign req    = wb_cyc_i & wb_stb_i;
  assign wr_now = req & wb_we_i & ack_q & wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // override pairs per pin
  always_comb
  begin
    direction_override_enable  = 8'h00;
    direction_override_value  = 8'h00;
    port_value_override_enable  = 8'h00;
    port_value_override_value  = 8'h00;
    input_enable_override_enable = 8'h00;
    input_enable_override_value = 8'h00;
    // converter pin: forced input, digital input off
    direction_override_enable[PCO_PIN_CONV]  = converter_output_enable_i;
    input_enable_override_enable[PCO_PIN_CONV] = converter_output_enable_i;
    // analog pins: only input enable overridden, value zero
    input_enable_override_enable[6] = ctrl_q[PCO_CTRL_AD10D];
    input_enable_override_enable[5] = ctrl_q[PCO_CTRL_AD9D];
    input_enable_override_enable[4] = ctrl_q[PCO_CTRL_AD8D];
    // stage outputs take direction and value
    direction_override_enable[PCO_PIN_S2O3] = stage2_out3_enable_i;
    direction_override_value[PCO_PIN_S2O3] = 1'b1;
    port_value_override_enable[PCO_PIN_S2O3] = stage2_out3_enable_i;
    port_value_override_value[PCO_PIN_S2O3] = stage2_out3_value_i;
    direction_override_enable[PCO_PIN_S2O2] = stage2_out2_enable_i;
    direction_override_value[PCO_PIN_S2O2] = 1'b1;
    port_value_override_enable[PCO_PIN_S2O2] = stage2_out2_enable_i;
    port_value_override_value[PCO_PIN_S2O2] = stage2_out2_value_i;
    // compare b: value only, direction stays with software
    port_value_override_enable[PCO_PIN_CMPB] = timer1_compare_b_enable_i;
    port_value_override_value[PCO_PIN_CMPB] = timer1_compare_b_out_i;
    // pin 0: stage 1 output and irq 3 input
    direction_override_enable[PCO_PIN_S1O0]  = stage1_out0_enable_i;
    direction_override_value[PCO_PIN_S1O0]  = 1'b1;
    port_value_override_enable[PCO_PIN_S1O0]  = stage1_out0_enable_i;
    port_value_override_value[PCO_PIN_S1O0]  = stage1_out0_value_i;
    input_enable_override_enable[PCO_PIN_S1O0] = ext_irq3_enable_i;
    input_enable_override_value[PCO_PIN_S1O0] = ext_irq3_enable_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad drive, combinational from registers and peripherals
  always_comb
  begin
    for (int i = 0; i < PCO_PINS; i++)
    begin
      // pin 1 leaves direction to software for compare b
      pad_oe_o[i]       = ovr(direction_override_enable[i], direction_override_value[i], dir_q[i]);
      pad_out_o[i]      = ovr(port_value_override_enable[i], port_value_override_value[i], out_q[i]);
      pad_input_en_o[i] = ovr(input_enable_override_enable[i], input_enable_override_value[i], 1'b1);
      // no pull-up override anywhere; comparator pins rely on
      // software clearing the port bit
      pad_pullup_o[i]   = out_q[i] & ~dir_q[i]
                        & ~ctrl_q[PCO_CTRL_PUD];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sampled pin levels to peripherals
  assign timer1_clock_input_o   = pin_q[PCO_PIN_S2O3];
  assign timer0_clock_input_o   = pin_q[PCO_PIN_S2O2];
  assign stage1_digital_input_o = pin_q[PCO_PIN_CMPB];
  assign ext_irq3_input_o       = pin_q[PCO_PIN_S1O0];

  ////////////////////////////////////////////////////////////////////////////
  // next state: bus writes, read data, pin sampling
  always_comb
  begin
    out_d  = out_q;
    dir_d  = dir_q;
    ctrl_d = ctrl_q;
    rdat_d = rdat_q;
    // a disabled digital input reads as zero
    pin_d  = pad_in_i & pad_input_en_o;
    // answer one cycle after request, drop the cycle after
    ack_d  = req & ~ack_q;
    // read data captured while the answer is built
    if (req & ~ack_q)
    begin
      unique case (wb_adr_i)
        PCO_OFS_OUT:  rdat_d = {24'h000000, out_q};
        PCO_OFS_DIR:  rdat_d = {24'h000000, dir_q};
        PCO_OFS_PIN:  rdat_d = {24'h000000, pin_q};
        PCO_OFS_CTRL: rdat_d = {24'h000000, ctrl_q};
        default:      rdat_d = 32'h00000000; // unmapped reads zero
      endcase
    end
    // write takes effect at the edge where ack is seen; a master that
    // holds stb past ack gets another answer and another write two cycles later
    if (wr_now)
    begin
      unique case (wb_adr_i)
        PCO_OFS_OUT:  out_d  = wb_dat_i[7:0];
        PCO_OFS_DIR:  dir_d  = wb_dat_i[7:0];
        PCO_OFS_CTRL: ctrl_d = wb_dat_i[7:0];
        default:      ; // read-only or unmapped: ignored
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_q  <= PCO_RST_OUT;
      dir_q  <= PCO_RST_DIR;
      ctrl_q <= PCO_RST_CTRL;
      pin_q  <= PCO_RST_PIN;
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end
    else
    begin
      out_q  <= out_d;
      dir_q  <= dir_d;
      ctrl_q <= ctrl_d;
      pin_q  <= pin_d;
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // converter pin: neither driven nor read digitally
  property p_conv_dir;
    converter_output_enable_i |-> !pad_oe_o[7] && !pad_input_en_o[7];
  endproperty
  a_conv_dir: assert property (p_conv_dir)
    else $error("converter pin not forced to input");

  property p_analog_dir;
    pad_oe_o[6:4] == dir_q[6:4];
  endproperty
  a_analog_dir: assert property (p_analog_dir)
    else $error("analog pin direction overridden");

  // every disabled analog pin has its digital input off
  property p_analog_ie;
    (ctrl_q[PCO_CTRL_AD10D:PCO_CTRL_AD8D] & pad_input_en_o[6:4])
      == 3'b000;
  endproperty
  a_analog_ie: assert property (p_analog_ie)
    else $error("disabled analog pin input still on");

  // stage 2 pins 3 and 2 turn to outputs, pin 1 stays with software
  property p_stage_dir;
    stage2_out3_enable_i && stage2_out2_enable_i |->
      pad_oe_o[3] && pad_oe_o[2] && pad_oe_o[1] == dir_q[1];
  endproperty
  a_stage_dir: assert property (p_stage_dir)
    else $error("stage pins not driven as outputs");

  property p_stage_val;
    stage2_out3_enable_i |-> pad_out_o[3] == stage2_out3_value_i;
  endproperty
  a_stage_val: assert property (p_stage_val)
    else $error("stage value missing on pin 3");

  // compare b value reaches pin 1 whenever its enable is up
  property p_cmpb;
    timer1_compare_b_enable_i |->
      pad_out_o[1] == timer1_compare_b_out_i;
  endproperty
  a_cmpb: assert property (p_cmpb)
    else $error("compare b not on pin 1");

  // overrides never move the pull-ups of pins 3..0: with the port
  // registers steady, the pull-ups stay put whatever the peripherals do
  property p_pullup;
    $stable(out_q) && $stable(dir_q) && $stable(ctrl_q) |->
      $stable(pad_pullup_o[3:0]);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up overridden on low pins");

  // irq 3 sees the pin level one cycle later
  property p_irq3;
    ext_irq3_enable_i |=> ext_irq3_input_o == $past(pad_in_i[0]);
  endproperty
  a_irq3: assert property (p_irq3)
    else $error("irq 3 input not delivered");

  property p_pin0;
    stage1_out0_enable_i |->
      pad_oe_o[0] && pad_out_o[0] == stage1_out0_value_i;
  endproperty
  a_pin0: assert property (p_pin0)
    else $error("stage 1 output 0 not on pin 0");

  // without the converter, software owns pin 7 direction
  property p_pass;
    !converter_output_enable_i |-> pad_oe_o[7] == dir_q[7];
  endproperty
  a_pass: assert property (p_pass)
    else $error("port direction not passed through");

  // timer 1 clock is the sampled level of pin 3
  property p_tclk;
    pad_input_en_o[3] ##1 pad_input_en_o[3] |->
      timer1_clock_input_o == $past(pad_in_i[3]);
  endproperty
  a_tclk: assert property (p_tclk)
    else $error("timer 1 clock not from pin 3");

  // one answer per request, one cycle long
  property p_ack;
    req && !ack_q |=> ack_q ##1 !ack_q;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus answer not one cycle");

  // main scenarios the bench should reach
  c_conv:  cover property (converter_output_enable_i);
  c_anlg:  cover property (|ctrl_q[PCO_CTRL_AD10D:PCO_CTRL_AD8D]);
  c_stage: cover property (stage1_out0_enable_i && ext_irq3_enable_i);
  c_write: cover property (wr_now && wb_adr_i == PCO_OFS_DIR);
  c_cmpb:  cover property (timer1_compare_b_enable_i && dir_q[1]);

endmodule : pco_port_c_override

`default_nettype wire

// ===== dv/pco_pad_model.sv
// pco_pad_model: pads of port c with external sources behind them
// assumes the bench picks which pins an outside source drives, and how
`timescale 1ns/100ps
`default_nettype none

module pco_pad_model
  import pco_pkg::*;
(
  // clock
  input  wire logic                clk_i,
  // pad side of the block
  input  wire logic [PCO_PINS-1:0] pad_out_i,
  input  wire logic [PCO_PINS-1:0] pad_oe_i,
  input  wire logic [PCO_PINS-1:0] pad_pullup_i,
  // outside sources
  input  wire logic [PCO_PINS-1:0] ext_drv_i,
  input  wire logic [PCO_PINS-1:0] ext_lvl_i,
  // level seen by the block
  output logic      [PCO_PINS-1:0] pad_in_o
);

  logic [PCO_PINS-1:0] float_q = 8'h5a; // undriven pins wander

  ////////////////////////////////////////////////////////////////////////////
  // floating pins flip every cycle so no stale level passes as good
  always_ff @(posedge clk_i)
    float_q <= ~float_q;

  // pad drive beats outside source, then pull-up, then float
  always_comb
    for (int i = 0; i < PCO_PINS; i++)
      pad_in_o[i] = pad_oe_i[i] ? pad_out_i[i] : ext_drv_i[i] ? ext_lvl_i[i]
                  : pad_pullup_i[i] ? 1'b1 : float_q[i];

endmodule : pco_pad_model
`default_nettype wire

// ===== dv/pco_port_c_override_tb.sv
// pco_port_c_override_tb: register and override checks of port c
// assumes one 40 MHz clock and the pad model on the pins
`timescale 1ns/100ps
`default_nettype none

module pco_port_c_override_tb;
  import pco_pkg::*;

  logic        clk_i = 1'b0, rst_i = 1'b1;      // clock, reset
  logic        cyc = 1'b0, stb = 1'b0;          // bus request
  logic        we = 1'b0;                       // bus direction
  logic [7:0]  adr = 8'h00;                     // byte address
  logic [3:0]  sel = 4'h0;                      // byte lanes
  logic [31:0] wdat = 32'h0, rdat;              // bus data
  logic        ack;                             // bus answer
  logic        cv = 1'b0, e3 = 1'b0;            // override enables
  logic        e2 = 1'b0, e0 = 1'b0;            // override enables
  logic        v3 = 1'b0, v2 = 1'b0, v0 = 1'b0; // stage values
  logic        cb = 1'b0, cbe = 1'b0;           // compare b
  logic        irq = 1'b0;                      // irq 3 enable
  logic        irq_in, s1_in, t0_in, t1_in;     // sampled inputs
  logic [7:0]  pin, pout, poe, ppu, pie;        // pads
  // outside sources hold the pins low until the pads drive them
  logic [7:0]  drv = 8'hff, lvl = 8'h00;        // outside sources
  int          failures = 0, samples_checked = 0;

  always #12.5 clk_i = ~clk_i;

  pco_port_c_override i_pco_port_c_override (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .converter_output_enable_i(cv),
    .stage2_out3_enable_i(e3), .stage2_out2_enable_i(e2),
    .stage1_out0_enable_i(e0), .stage2_out3_value_i(v3),
    .stage2_out2_value_i(v2), .stage1_out0_value_i(v0),
    .timer1_compare_b_out_i(cb), .timer1_compare_b_enable_i(cbe),
    .ext_irq3_enable_i(irq), .ext_irq3_input_o(irq_in),
    .stage1_digital_input_o(s1_in), .timer0_clock_input_o(t0_in),
    .timer1_clock_input_o(t1_in), .pad_in_i(pin), .pad_out_o(pout),
    .pad_oe_o(poe), .pad_pullup_o(ppu), .pad_input_en_o(pie));

  pco_pad_model i_pco_pad_model (
    .clk_i(clk_i), .pad_out_i(pout), .pad_oe_i(poe), .pad_pullup_i(ppu),
    .ext_drv_i(drv), .ext_lvl_i(lvl), .pad_in_o(pin));

  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // one comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // classic single cycle; ack and read data taken at the rising edge,
  // request released at that edge, returns settled at the next fall
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [7:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
      if (n > 16)
      begin
        failures++;
        $display("Error %0t: no bus answer", $time);
        finish_test();
      end
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(negedge clk_i);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s = 4'hf);
    logic [31:0] r;
    wb(1'b1, a, d, s, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    wb(1'b0, a, 8'h00, 4'hf, r);
    chk(r[7:0], e);
    chk(r[31:24] | r[23:16] | r[15:8], 8'h00);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped place
    rd(PCO_OFS_OUT, PCO_RST_OUT); rd(PCO_OFS_DIR, PCO_RST_DIR);
    rd(PCO_OFS_CTRL, PCO_RST_CTRL); rd(PCO_OFS_PIN, PCO_RST_PIN);
    rd(8'h10, 8'h00); wr(8'h10, 8'hff);
    chk(poe, 8'h00); chk(pie, 8'hff);
    // plain port, ignored writes
    wr(PCO_OFS_OUT, 8'ha5); wr(PCO_OFS_DIR, 8'hff);
    wr(PCO_OFS_OUT, 8'h00, 4'he); wr(PCO_OFS_PIN, 8'h00);
    rd(PCO_OFS_OUT, 8'ha5); rd(PCO_OFS_PIN, 8'ha5);
    chk(pout, 8'ha5); chk(poe, 8'hff);
    // converter output on pin 7
    @(posedge clk_i) cv <= 1;
    @(negedge clk_i) chk(poe, 8'h7f);
    chk(pie, 8'h7f); chk(pout, 8'ha5);
    @(posedge clk_i) cv <= 0;
    wr(PCO_OFS_CTRL, 8'h70);
    @(negedge clk_i) chk(pie, 8'h8f);
    rd(PCO_OFS_PIN, 8'h85);
    // stage and compare overrides, pin 1 direction left to software
    wr(PCO_OFS_CTRL, 8'h00); wr(PCO_OFS_DIR, 8'h00);
    wr(PCO_OFS_OUT, 8'h0f);
    for (int v = 0; v < 2; v++)
    begin
      @(posedge clk_i);
      {e3, e2, e0, cbe} <= 4'hf;
      {v3, v2, v0, cb} <= {4{v[0]}};
      @(negedge clk_i) chk(poe, 8'h0d);
      chk(pout, {4'h0, {4{v[0]}}});
      chk(ppu, 8'h0f);
    end
    wr(PCO_OFS_DIR, 8'h02);
    @(negedge clk_i) chk(poe, 8'h0f);
    @(posedge clk_i) {e3, e2, e0, cbe} <= 4'h0;
    @(negedge clk_i) chk(pout, 8'h0f);
    chk(poe, 8'h02);
    wr(PCO_OFS_CTRL, 8'h01);
    @(negedge clk_i) chk(ppu, 8'h00);
    // sampled inputs towards timers, stage 1 and irq 3
    wr(PCO_OFS_DIR, 8'h00); wr(PCO_OFS_OUT, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_i);
      irq <= 1'b1;
      drv <= 8'hff;
      lvl <= k ? 8'h02 : 8'h0d;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk({4'h0, t1_in, t0_in, s1_in, irq_in},
          {4'h0, lvl[3:0]});
      chk({7'h00, pie[0]}, 8'h01);
      rd(PCO_OFS_PIN, lvl);
    end
    finish_test();
  end

endmodule : pco_port_c_override_tb
`default_nettype wire
